// File: pkg/sfc_pkg.sv
// Purpose: shared constants for the serial flash command framing block
// Assumes: single I/O link, four address bytes on array commands other than chip erase
// Notes: command info is a flag vector indexed by the INF_ positions
package sfc_pkg;

    // Command info flag positions
    localparam int INF_READ = 0;
    localparam int INF_WRITE = 1;
    localparam int INF_ADDR = 2;
    localparam int INF_DIN = 3;
    localparam int INF_ARRAY = 4;
    localparam int INF_W = 5;
    localparam logic [INF_W-1:0] INF_NONE = 5'h00;

    // Opcodes
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_RDID = 8'h9f;
    localparam logic [7:0] OP_RDSR = 8'h05;
    localparam logic [7:0] OP_RDCR = 8'h15;
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_WRSR = 8'h01;
    localparam logic [7:0] OP_SE = 8'h20;
    localparam logic [7:0] OP_BE32 = 8'h52;
    localparam logic [7:0] OP_BE64 = 8'hd8;
    localparam logic [7:0] OP_CE = 8'hc7;
    localparam logic [7:0] OP_PP = 8'h02;
    localparam logic [7:0] OP_DP = 8'hb9;
    localparam logic [7:0] OP_RSTEN = 8'h66;
    localparam logic [7:0] OP_RST = 8'h99;

    // Bit counts within a phase
    localparam logic [5:0] BIT_LAST_BYTE = 6'h07;
    localparam logic [5:0] BIT_LAST_ADDR = 6'h1f;
    localparam logic [2:0] OUT_LAST_BIT = 3'h7;

    // Array map: 4 KB sectors, 32 KB and 64 KB blocks, 128 MB array
    localparam int SECTOR_LSB = 12;
    localparam int BLK32_LSB = 15;
    localparam int BLK64_LSB = 16;
    localparam int ARRAY_MSB = 26;
    localparam logic [10:0] BLK64_FIRST = 11'h000;
    localparam logic [10:0] BLK64_LAST = 11'h7ff;

endpackage

// File: hw/sfc_pin_sync.sv
// Purpose: two-flop synchroniser with edge pulses for one pin
// Assumes: pin is asynchronous to mclk
// Notes: edges are found on the second and third stages only
`timescale 1ns/1ns
`default_nettype none
module sfc_pin_sync #(
    parameter logic RST_VAL = 1'b0
) (
    // System
    input wire logic mclk,
    input wire logic resetn,
    // Pin
    input wire logic pin,
    // Synchronised view
    output logic lvl,
    output logic rise,
    output logic fall
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic s1_next;
    logic s2_next;
    logic s3_next;

    always_comb begin
        s1_next = pin;
        s2_next = s1_reg;
        s3_next = s2_reg;
    end

    // Reset to the pin's idle level, so no false edge follows reset
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s1_reg <= RST_VAL;
            s2_reg <= RST_VAL;
            s3_reg <= RST_VAL;
        end else begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
            s3_reg <= s3_next;
        end
    end

    assign lvl = s2_reg;
    assign rise = s2_reg & ~s3_reg;
    assign fall = ~s2_reg & s3_reg;
endmodule
`default_nettype wire

// File: hw/sfc_cmd_frame.sv
// Purpose: command framing front end of a serial NOR flash
// Assumes: sclk, cs_n, si asynchronous; wip and rd_data on mclk
// Notes: sclk period at least eight mclk periods
`timescale 1ns/1ns
`default_nettype none
module sfc_cmd_frame import sfc_pkg::*; (
    // System
    input wire logic mclk,
    input wire logic resetn,
    // Flash pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic si,
    output logic so_o,
    output logic so_oe,
    // Core status and read data
    input wire logic wip,
    input wire logic [7:0] rd_data,
    // Read channel
    output logic rd_req,
    output logic [7:0] rd_op,
    output logic [31:0] rd_addr,
    // Write data channel
    output logic din_stb,
    output logic [7:0] din_byte,
    // Command execution
    output logic exec_stb,
    output logic [7:0] exec_op,
    output logic [31:0] exec_addr,
    output logic [14:0] exec_sector,
    output logic [11:0] exec_blk32,
    output logic [10:0] exec_block,
    output logic exec_fine_lock,
    output logic reject_stb,
    output logic active
);
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_CMD = 5'h02,
        ST_ADDR = 5'h04,
        ST_DIN = 5'h08,
        ST_DOUT = 5'h10
    } sfc_state_t;

    function automatic logic [INF_W-1:0] cmd_info(input logic [7:0] op);
        logic [INF_W-1:0] f;
        f = INF_NONE;
        case (op)
            OP_READ: begin
                f[INF_READ] = 1'b1;
                f[INF_ADDR] = 1'b1;
                f[INF_ARRAY] = 1'b1;
            end
            OP_RDID, OP_RDSR, OP_RDCR: begin
                f[INF_READ] = 1'b1;
            end
            OP_SE, OP_BE32, OP_BE64: begin
                f[INF_WRITE] = 1'b1;
                f[INF_ADDR] = 1'b1;
                f[INF_ARRAY] = 1'b1;
            end
            OP_PP: begin
                f[INF_WRITE] = 1'b1;
                f[INF_ADDR] = 1'b1;
                f[INF_DIN] = 1'b1;
                f[INF_ARRAY] = 1'b1;
            end
            OP_CE: begin
                f[INF_WRITE] = 1'b1;
                f[INF_ARRAY] = 1'b1;
            end
            OP_WRSR: begin
                f[INF_WRITE] = 1'b1;
                f[INF_DIN] = 1'b1;
            end
            OP_WREN, OP_WRDI, OP_DP, OP_RSTEN, OP_RST: begin
                f[INF_WRITE] = 1'b1;
            end
            default: begin
                f = INF_NONE;
            end
        endcase
        return f;
    endfunction

    // Pin synchronisers: sclk, cs_n, si
    logic [2:0] pin_raw;
    logic [2:0] pin_lvl;
    logic [2:0] pin_rise;
    logic [2:0] pin_fall;
    localparam logic [2:0] PIN_RST = 3'h2;

    assign pin_raw = {si, cs_n, sclk};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            sfc_pin_sync #(
                .RST_VAL(PIN_RST[gi])
            ) u_sync (
                .mclk(mclk),
                .resetn(resetn),
                .pin(pin_raw[gi]),
                .lvl(pin_lvl[gi]),
                .rise(pin_rise[gi]),
                .fall(pin_fall[gi])
            );
        end
    endgenerate

    logic sclk_rise;
    logic sclk_fall;
    logic cs_lvl;
    logic cs_rise;
    logic cs_fall;
    logic si_lvl;
    assign sclk_rise = pin_rise[0];
    assign sclk_fall = pin_fall[0];
    assign cs_lvl = pin_lvl[1];
    assign cs_rise = pin_rise[1];
    assign cs_fall = pin_fall[1];
    assign si_lvl = pin_lvl[2];

    sfc_state_t state_reg, state_next;
    logic [5:0] bits_reg, bits_next;
    logic [7:0] op_reg, op_next;
    logic [INF_W-1:0] info_reg, info_next;
    logic [31:0] addr_reg, addr_next;
    logic [7:0] ish_reg, ish_next;
    logic [7:0] osh_reg, osh_next;
    logic [2:0] ocnt_reg, ocnt_next;
    logic got_reg, got_next;
    logic so_reg, so_next;
    logic oe_reg, oe_next;
    logic rdreq_reg, rdreq_next;
    logic [7:0] rdop_reg, rdop_next;
    logic [31:0] rdaddr_reg, rdaddr_next;
    logic dstb_reg, dstb_next;
    logic [7:0] dbyte_reg, dbyte_next;
    logic xstb_reg, xstb_next;
    logic [7:0] xop_reg, xop_next;
    logic [31:0] xaddr_reg, xaddr_next;
    logic rej_reg, rej_next;
    logic act_reg, act_next;
    logic fine_reg, fine_next;
    logic [7:0] sh;
    logic [INF_W-1:0] sh_info;
    logic [10:0] xblk;

    assign sh = {ish_reg[6:0], si_lvl};
    assign sh_info = cmd_info(sh);

    always_comb begin
        state_next = state_reg;
        bits_next = bits_reg;
        op_next = op_reg;
        info_next = info_reg;
        addr_next = addr_reg;
        ish_next = ish_reg;
        osh_next = osh_reg;
        ocnt_next = ocnt_reg;
        got_next = got_reg;
        so_next = so_reg;
        rdreq_next = 1'b0;
        rdop_next = rdop_reg;
        rdaddr_next = rdaddr_reg;
        dstb_next = 1'b0;
        dbyte_next = dbyte_reg;
        xstb_next = 1'b0;
        xop_next = xop_reg;
        xaddr_next = xaddr_reg;
        rej_next = 1'b0;
        if (cs_lvl) begin
            state_next = ST_IDLE;
            if (cs_rise && state_reg == ST_DIN) begin
                if (bits_reg[2:0] == 3'h0 &&
                    (!info_reg[INF_DIN] || got_reg)) begin
                    xstb_next = 1'b1;
                    xop_next = op_reg;
                    xaddr_next = addr_reg;
                end else begin
                    rej_next = 1'b1;
                end
            end else if (cs_rise && state_reg == ST_ADDR &&
                         info_reg[INF_WRITE]) begin
                rej_next = 1'b1;
            end
        end else if (state_reg == ST_IDLE) begin
            // only a fresh select fall leaves standby
            // no sclk level is assumed at select fall
            if (cs_fall) begin
                state_next = ST_CMD;
                bits_next = 6'h00;
                got_next = 1'b0;
            end
        end else if (sclk_rise && state_reg != ST_DOUT) begin
            // every input bit taken on sclk rise
            ish_next = sh;
            bits_next = bits_reg + 6'h01;
            case (state_reg)
                ST_CMD: begin
                    if (bits_reg == BIT_LAST_BYTE) begin
                        bits_next = 6'h00;
                        op_next = sh;
                        info_next = sh_info;
                        if (sh_info == INF_NONE) begin
                            state_next = ST_IDLE;
                            rej_next = 1'b1;
                        end else if (wip && sh_info[INF_ARRAY]) begin
                            state_next = ST_IDLE;
                        end else if (sh_info[INF_ADDR]) begin
                            state_next = ST_ADDR;
                        end else if (sh_info[INF_READ]) begin
                            state_next = ST_DOUT;
                            rdreq_next = 1'b1;
                            rdop_next = sh;
                            rdaddr_next = 32'h0000_0000;
                            ocnt_next = 3'h0;
                        end else begin
                            state_next = ST_DIN;
                        end
                    end
                end
                ST_ADDR: begin
                    addr_next = {addr_reg[30:0], si_lvl};
                    if (bits_reg == BIT_LAST_ADDR) begin
                        bits_next = 6'h00;
                        if (info_reg[INF_READ]) begin
                            state_next = ST_DOUT;
                            rdreq_next = 1'b1;
                            rdop_next = op_reg;
                            rdaddr_next = {addr_reg[30:0], si_lvl};
                            ocnt_next = 3'h0;
                        end else begin
                            state_next = ST_DIN;
                        end
                    end
                end
                ST_DIN: begin
                    if (bits_reg == BIT_LAST_BYTE) begin
                        bits_next = 6'h00;
                        got_next = 1'b1;
                        dstb_next = info_reg[INF_DIN];
                        dbyte_next = sh;
                    end
                end
                default: begin
                    state_next = ST_IDLE;
                end
            endcase
        end else if (sclk_fall && state_reg == ST_DOUT) begin
            // launch on sclk fall, fresh byte at bit 0
            if (ocnt_reg == 3'h0) begin
                so_next = rd_data[7];
                osh_next = {rd_data[6:0], 1'b0};
            end else begin
                so_next = osh_reg[7];
                osh_next = {osh_reg[6:0], 1'b0};
            end
            ocnt_next = ocnt_reg + 3'h1;
            if (ocnt_reg == OUT_LAST_BIT) begin
                rdreq_next = 1'b1;
            end
        end
        // output enabled only in the output phase
        oe_next = (state_next == ST_DOUT) && (oe_reg || sclk_fall);
        act_next = (state_next != ST_IDLE);
        // end blocks flagged for per-sector lock
        fine_next = (xaddr_next[ARRAY_MSB:BLK64_LSB] == BLK64_FIRST) ||
            (xaddr_next[ARRAY_MSB:BLK64_LSB] == BLK64_LAST);
    end

    // reset lands in standby with output released
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ST_IDLE;
            bits_reg <= 6'h00;
            op_reg <= 8'h00;
            info_reg <= INF_NONE;
            addr_reg <= 32'h0000_0000;
            ish_reg <= 8'h00;
            osh_reg <= 8'h00;
            ocnt_reg <= 3'h0;
            got_reg <= 1'b0;
            so_reg <= 1'b0;
            oe_reg <= 1'b0;
            rdreq_reg <= 1'b0;
            rdop_reg <= 8'h00;
            rdaddr_reg <= 32'h0000_0000;
            dstb_reg <= 1'b0;
            dbyte_reg <= 8'h00;
            xstb_reg <= 1'b0;
            xop_reg <= 8'h00;
            xaddr_reg <= 32'h0000_0000;
            rej_reg <= 1'b0;
            act_reg <= 1'b0;
            fine_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            bits_reg <= bits_next;
            op_reg <= op_next;
            info_reg <= info_next;
            addr_reg <= addr_next;
            ish_reg <= ish_next;
            osh_reg <= osh_next;
            ocnt_reg <= ocnt_next;
            got_reg <= got_next;
            so_reg <= so_next;
            oe_reg <= oe_next;
            rdreq_reg <= rdreq_next;
            rdop_reg <= rdop_next;
            rdaddr_reg <= rdaddr_next;
            dstb_reg <= dstb_next;
            dbyte_reg <= dbyte_next;
            xstb_reg <= xstb_next;
            xop_reg <= xop_next;
            xaddr_reg <= xaddr_next;
            rej_reg <= rej_next;
            act_reg <= act_next;
            fine_reg <= fine_next;
        end
    end

    // sector and block indices from the array address
    // 64 KB block is the normal lock unit
    // end blocks lock per sector instead
    assign xblk = xaddr_reg[ARRAY_MSB:BLK64_LSB];
    assign exec_sector = xaddr_reg[ARRAY_MSB:SECTOR_LSB];
    assign exec_blk32 = xaddr_reg[ARRAY_MSB:BLK32_LSB];
    assign exec_block = xblk;
    assign exec_fine_lock = fine_reg;

    assign so_o = so_reg;
    assign so_oe = oe_reg;
    assign rd_req = rdreq_reg;
    assign rd_op = rdop_reg;
    assign rd_addr = rdaddr_reg;
    assign din_stb = dstb_reg;
    assign din_byte = dbyte_reg;
    assign exec_stb = xstb_reg;
    assign exec_op = xop_reg;
    assign exec_addr = xaddr_reg;
    assign reject_stb = rej_reg;
    assign active = act_reg;

    a_standby_hiz:
        assert property (@(posedge mclk) disable iff (!resetn)
            state_reg == ST_IDLE |=> !so_oe)
        else $error("data output driven in standby");
    a_invalid_standby:
        assert property (@(posedge mclk) disable iff (!resetn)
            (state_reg == ST_CMD && !cs_lvl && sclk_rise &&
             bits_reg == BIT_LAST_BYTE && sh_info == INF_NONE)
            |=> state_reg == ST_IDLE && reject_stb)
        else $error("invalid opcode did not reach standby");
    a_stay_standby:
        assert property (@(posedge mclk) disable iff (!resetn)
            state_reg == ST_IDLE && !cs_fall |=> state_reg == ST_IDLE)
        else $error("standby left without select fall");
    a_rise_ends:
        assert property (@(posedge mclk) disable iff (!resetn)
            cs_rise |=> !active ##1 !active && !so_oe)
        else $error("active after select rise");
    a_launch_fall:
        assert property (@(posedge mclk) disable iff (!resetn)
            so_oe && $changed(so_o) |-> $past(sclk_fall))
        else $error("output bit changed off sclk fall");
    a_sample_rise:
        assert property (@(posedge mclk) disable iff (!resetn)
            state_reg == ST_CMD && !cs_lvl && !sclk_rise
            |=> $stable(ish_reg) && $stable(bits_reg))
        else $error("input shifted without sclk rise");
    a_exec_aligned:
        assert property (@(posedge mclk) disable iff (!resetn)
            exec_stb |-> $past(bits_reg[2:0]) == 3'h0 && !reject_stb)
        else $error("write command run off byte boundary");
    a_unaligned_drop:
        assert property (@(posedge mclk) disable iff (!resetn)
            cs_rise && state_reg == ST_DIN && bits_reg[2:0] != 3'h0
            |=> reject_stb && !exec_stb)
        else $error("unaligned write command not discarded");
    a_busy_ignore:
        assert property (@(posedge mclk) disable iff (!resetn)
            (state_reg == ST_CMD && !cs_lvl && sclk_rise && wip &&
             bits_reg == BIT_LAST_BYTE && sh_info[INF_ARRAY])
            |=> state_reg == ST_IDLE && !rd_req ##1 !exec_stb)
        else $error("array access taken while busy");
    a_oe_phase:
        assert property (@(posedge mclk) disable iff (!resetn)
            so_oe |-> state_reg == ST_DOUT && active)
        else $error("output enabled outside data phase");
endmodule
`default_nettype wire

// File: tb/sfc_host_model.sv
// Purpose: host controller model driving the serial flash link
// Assumes: one bit per sclk period of eight mclk cycles
// Notes: frames are driven through the xfer task
`timescale 1ns/1ns
`default_nettype none
module sfc_host_model (
    // System
    input wire logic mclk,
    // Link
    output logic sclk,
    output logic cs_n,
    output logic si,
    input wire logic so_o,
    input wire logic so_oe,
    // Setup
    input wire logic mode3
);
    logic so_last;
    logic so_line;

    // Released line shows the inverse of its last level
    assign so_line = so_oe ? so_o : ~so_last;

    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        so_last = 1'b0;
    end

    // Data line keeps moving outside frames, never parked
    always @(posedge mclk) begin
        so_last <= so_line;
        if (cs_n) begin
            si <= ~si;
        end
    end

    // idle level by mode, nin bits driven then ntot - nin read, stop on any bit
    task automatic xfer(input logic [63:0] bits, input int nin,
        input int ntot, output logic [63:0] got);
        got = '0;
        @(posedge mclk);
        sclk <= mode3;
        repeat (4) @(posedge mclk);
        cs_n <= 1'b0;
        repeat (2) @(posedge mclk);
        for (int i = 0; i < ntot; i++) begin
            sclk <= 1'b0;
            si <= (i < nin) ? bits[63 - i] : ~si;
            repeat (4) @(posedge mclk);
            sclk <= 1'b1;
            repeat (3) @(posedge mclk);
            @(negedge mclk);
            if (i >= nin) got = {got[62:0], so_line};
            @(posedge mclk);
        end
        if (!mode3) begin
            sclk <= 1'b0;
            repeat (4) @(posedge mclk);
        end
        cs_n <= 1'b1;
        repeat (10) @(posedge mclk);
    endtask
endmodule
`default_nettype wire

// File: tb/sfc_cmd_frame_tb.sv
// Purpose: self-checking bench for the command framing block
// Assumes: host model drives the link, bench plays the core side
// Notes: read bytes follow a fixed function of address and index
`timescale 1ns/1ns
`default_nettype none
module sfc_cmd_frame_tb import sfc_pkg::*; ;
    logic mclk, resetn, sclk, cs_n, si, so_o, so_oe, wip, mode3;
    logic [7:0] rd_data, rd_op, din_byte, exec_op, op, dv, rcnt;
    logic [31:0] rd_addr, exec_addr, a;
    logic [14:0] exec_sector;
    logic [11:0] exec_blk32;
    logic [10:0] exec_block;
    logic rd_req, din_stb, exec_stb, exec_fine_lock, reject_stb, active;
    logic act_seen, oe_seen;
    logic [63:0] got;
    int n_exec, n_rej, n_din, n_req, e0, r0, d0, q0;
    int fails, n_compared, cycles, nin, nout;
    logic [7:0] wops [11];
    logic [7:0] rops [4];
    logic [7:0] aops [6];

    sfc_cmd_frame u_dut (.mclk(mclk), .resetn(resetn), .sclk(sclk),
        .cs_n(cs_n), .si(si), .so_o(so_o), .so_oe(so_oe), .wip(wip),
        .rd_data(rd_data), .rd_req(rd_req), .rd_op(rd_op),
        .rd_addr(rd_addr), .din_stb(din_stb), .din_byte(din_byte),
        .exec_stb(exec_stb), .exec_op(exec_op), .exec_addr(exec_addr),
        .exec_sector(exec_sector), .exec_blk32(exec_blk32),
        .exec_block(exec_block), .exec_fine_lock(exec_fine_lock),
        .reject_stb(reject_stb), .active(active));

    sfc_host_model u_host (.mclk(mclk), .sclk(sclk), .cs_n(cs_n),
        .si(si), .so_o(so_o), .so_oe(so_oe), .mode3(mode3));

    always #10 mclk = ~mclk;

    function automatic logic [7:0] exp_byte(logic [31:0] ad, logic [7:0] k);
        return ad[7:0] + ad[23:16] + (k * 8'h3b);
    endfunction

    function automatic logic has_addr(logic [7:0] c);
        return c inside {OP_READ, OP_SE, OP_BE32, OP_BE64, OP_PP};
    endfunction

    function automatic logic [63:0] exp_bits(logic [31:0] ad, int n);
        logic [63:0] e;
        logic [7:0] b;
        e = '0;
        for (int j = 0; j < n; j++) begin
            b = exp_byte(ad, j[10:3]);
            e = {e[62:0], b[7 - j % 8]};
        end
        return e;
    endfunction

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: seen %h, expected %h", $time,
                seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("Compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic frame(input logic [7:0] c, input logic [31:0] ad,
        input logic [15:0] d, input int ni, input int no);
        logic [63:0] bits;
        bits = has_addr(c) ? {c, ad, d, 8'h00} : {c, d, 40'h0};
        mode3 <= ($urandom_range(1) == 1);
        e0 = n_exec;
        r0 = n_rej;
        d0 = n_din;
        q0 = n_req;
        act_seen = 1'b0;
        oe_seen = 1'b0;
        u_host.xfer(bits, ni, ni + no, got);
    endtask

    // Core side and pulse monitor; exec fields checked as they pulse
    always @(posedge mclk) begin
        cycles++;
        if (rd_req) begin
            rd_data <= exp_byte(rd_addr, rcnt);
            rcnt <= rcnt + 8'h01;
            n_req++;
        end else if (cs_n) begin
            rcnt <= 8'h00;
        end
        if (!cs_n && active) act_seen = 1'b1;
        if (!cs_n && so_oe) oe_seen = 1'b1;
        if (reject_stb) n_rej++;
        if (din_stb) begin
            n_din++;
            check(din_byte, dv);
        end
        if (exec_stb) begin
            n_exec++;
            check(exec_op, op);
            if (has_addr(op)) begin
                check(exec_addr, a);
                check(exec_sector, a[26:12]);
                check(exec_blk32, a[26:15]);
                check(exec_block, a[26:16]);
                check(exec_fine_lock,
                    a[26:16] inside {BLK64_FIRST, BLK64_LAST});
            end
        end
        if (cycles == 80000) begin
            fails++;
            tally_and_finish();
        end
    end

    initial begin
        mclk = 1'b0;
        resetn = 1'b0;
        wip = 1'b0;
        mode3 = 1'b0;
        rd_data = 8'h00;
        rcnt = 8'h00;
        {n_exec, n_rej, n_din, n_req, fails, n_compared, cycles} = '0;
        wops = '{OP_WREN, OP_WRDI, OP_WRSR, OP_SE, OP_BE32, OP_BE64, OP_CE,
            OP_PP, OP_DP, OP_RSTEN, OP_RST};
        rops = '{OP_READ, OP_RDID, OP_RDSR, OP_RDCR};
        aops = '{OP_READ, OP_SE, OP_BE32, OP_BE64, OP_CE, OP_PP};
        void'($urandom(24805));
        repeat (2) @(posedge mclk);
        check(active, 1'b0);
        check(so_oe, 1'b0);
        resetn <= 1'b1;
        repeat (6) @(posedge mclk);
        for (int r = 0; r < 4; r++) begin
            for (int i = 0; i < 11; i++) begin
                op = wops[i];
                a = (r == 0) ? 32'h0000ffff : (r == 1) ? 32'h07ff0000 :
                    $urandom;
                dv = 8'($urandom);
                nin = has_addr(op) ? 40 : 8;
                if (op inside {OP_WRSR, OP_PP}) nin = nin + 8;
                frame(op, a, {dv, 8'h00}, nin, 0);
                check(n_exec - e0, 1);
                check(n_din - d0, (op inside {OP_WRSR, OP_PP}));
                check(n_rej - r0, 0);
                check(act_seen, 1'b1);
                check(active, 1'b0);
            end
        end
        for (int r = 0; r < 4; r++) begin
            for (int i = 0; i < 4; i++) begin
                op = rops[i];
                a = $urandom;
                nout = (r == 0) ? 8 : 1 + $urandom_range(23);
                frame(op, a, 16'h0000, has_addr(op) ? 40 : 8, nout);
                check(got, exp_bits(has_addr(op) ? a : 32'h0, nout));
                check(rd_op, op);
                check(n_rej - r0 + n_exec - e0, 0);
                check(act_seen, 1'b1);
            end
        end
        for (int i = 0; i < 3; i++) begin
            do op = 8'($urandom); while (op inside {wops, rops});
            frame(op, 32'h0, {OP_WREN, OP_RDSR}, 24, 16);
            check(n_rej - r0, 1);
            check(n_exec - e0 + n_req - q0, 0);
            check(oe_seen, 1'b0);
            check(active, 1'b0);
        end
        for (int i = 0; i < 6; i++) begin
            op = (i % 2 == 1) ? OP_SE : OP_WREN;
            nin = (op == OP_SE) ? 9 + $urandom_range(37) :
                9 + $urandom_range(6);
            if (nin % 8 == 0) nin++;
            frame(op, $urandom, 16'h0000, nin, 0);
            check(n_rej - r0, 1);
            check(n_exec - e0, 0);
        end
        wip <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            op = aops[i];
            a = $urandom;
            nin = has_addr(op) ? 40 : 8;
            if (op == OP_PP) nin = nin + 8;
            frame(op, a, 16'ha5a5, nin, (op == OP_READ) ? 8 : 0);
            check(n_exec - e0 + n_rej - r0, 0);
            check(n_req - q0 + n_din - d0, 0);
        end
        frame(OP_RDSR, 32'h0, 16'h0000, 8, 12);
        check(got, exp_bits(32'h0, 12));
        wip <= 1'b0;
        tally_and_finish();
    end
endmodule
`default_nettype wire
